// [logic/svec_ctrl.sv]
// stereo volume/balance controller with encoder, buttons, lamps
// assumes one clock, AXI4-Lite slave, zero-cross inputs on clock_i
//
// Overview of operation
// - up step: louder, or balance rightward
// - down step: quieter, or balance leftward
// - volume steps move both taps together
// - no louder once a wiper tops out
// - at bottom, only other wiper keeps falling
// - raising restores the earlier separation
// - both at 31, down mutes; up returns
// - tap n is 2n dB; 32 mutes
// - equal: rightward attenuates left only
// - right quieter: rightward raises right wiper
// - taps move on zero cross or 32ms
// - second wiper forced within 32ms
// - power-on: mute, then tap 6
// - power-on: volume mode, lamp off
// - power down parks wipers, release restores
// - mute press toggles mute
// - up step cancels mute
// - mode lamp on in balance mode
// - volume mode: five-step bar graph
// - balance mode: exactly one lamp lit
// - two buttons pressed: no action
// - mode button falling edge toggles mode
`timescale 1ns/1ps
`include "svec_cfg.svh"
module svec_ctrl #(
   parameter int unsigned DEB_CYC = `SVEC_DEB_CYC,
   parameter int unsigned TMO_CYC = `SVEC_TMO_CYC,
   parameter int BAL_FAR = `SVEC_BAL_FAR
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // encoder and buttons, active low
   input wire logic encoder_phase_a_n_i,
   input wire logic encoder_phase_b_n_i,
   input wire logic mute_button_n_i,
   input wire logic mode_button_n_i,
   input wire logic power_down_n_i,
   // zero crossing per channel, 0 left 1 right
   input wire logic [1:0] zero_cross_i,
   // wiper tap codes
   output logic [5:0] left_channel_tap_o,
   output logic [5:0] right_channel_tap_o,
   // open-drain lamps
   output logic mode_lamp_n_o,
   output logic mode_lamp_oe_o,
   output logic [4:0] level_lamp_n_o,
   output logic [4:0] level_lamp_oe_o,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int DW = $clog2(DEB_CYC + 1);
   localparam int TW = $clog2(TMO_CYC + 1);

   // ==========================================================
   // input synchronisers and debounce
   // ==========================================================
   logic [3:0] raw, s1_q, s2_q, db_q, dbp_q;
   logic pd1_q, pd2_q;
   assign raw = {mode_button_n_i, mute_button_n_i,
                 encoder_phase_b_n_i, encoder_phase_a_n_i};

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         dbp_q <= 4'hF;
         pd1_q <= 1'h1;
         pd2_q <= 1'h1;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         dbp_q <= db_q;
         pd1_q <= power_down_n_i;
         pd2_q <= pd1_q;
      end
   end

   // level must hold a full debounce time before it is taken
   for (genvar g = 0; g < 4; g++) begin : g_deb
      logic [DW-1:0] cnt_q;
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            cnt_q <= '0;
            db_q[g] <= 1'h1;
         end else if (s2_q[g] == db_q[g]) begin
            cnt_q <= '0;
         end else if (cnt_q == DW'(DEB_CYC - 1)) begin
            cnt_q <= '0;
            db_q[g] <= s2_q[g];
         end else begin
            cnt_q <= cnt_q + DW'(1);
         end
      end
   end

   // ==========================================================
   // encoder decode and button events
   // ==========================================================
   logic [1:0] cur, prv, dlt;
   logic hold, down, busy, up, dn, mute_press, mode_press;
   assign cur = {db_q[1], db_q[1] ^ db_q[0]};
   assign prv = {dbp_q[1], dbp_q[1] ^ dbp_q[0]};
   assign dlt = cur - prv;
   assign hold = !db_q[2] && !db_q[3];
   assign down = !pd2_q;
   assign busy = hold || down;
   assign up = (dlt == 2'h1) && !busy;
   assign dn = (dlt == 2'h3) && !busy;
   assign mute_press = dbp_q[2] && !db_q[2] && db_q[3];
   assign mode_press = dbp_q[3] && !db_q[3] && db_q[2];

   // ==========================================================
   // settings: logical taps, mute state, mode
   // ==========================================================
   logic [6:0] ll_q, lr_q;
   logic [5:0] al, ar;
   logic bal_q, vol_ok;
   svec_pkg::svec_st_t st_q;
   // logical taps run past 31 so the separation survives
   assign al = (ll_q > 7'h1F) ? `SVEC_TAP_MIN : ll_q[5:0];
   assign ar = (lr_q > 7'h1F) ? `SVEC_TAP_MIN : lr_q[5:0];
   assign vol_ok = !bal_q && (st_q == svec_pkg::SVEC_RUN);

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ll_q <= `SVEC_TAP_POR;
         lr_q <= `SVEC_TAP_POR;
      end else if (vol_ok && up) begin
         if (ll_q != 7'h00 && lr_q != 7'h00) begin
            ll_q <= ll_q - 7'h01;
            lr_q <= lr_q - 7'h01;
         end
      end else if (vol_ok && dn) begin
         if (al != `SVEC_TAP_MIN || ar != `SVEC_TAP_MIN) begin
            ll_q <= ll_q + 7'h01;
            lr_q <= lr_q + 7'h01;
         end
      end else if (st_q == svec_pkg::SVEC_RUN && up) begin
         if (lr_q > ll_q) begin
            lr_q <= lr_q - 7'h01;
         end else if (ll_q < 7'h1F) begin
            ll_q <= ll_q + 7'h01;
         end
      end else if (st_q == svec_pkg::SVEC_RUN && dn) begin
         if (ll_q > lr_q) begin
            ll_q <= ll_q - 7'h01;
         end else if (lr_q < 7'h1F) begin
            lr_q <= lr_q + 7'h01;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= svec_pkg::SVEC_RUN;
      end else begin
         case (st_q)
            svec_pkg::SVEC_RUN: begin
               if (mute_press) begin
                  st_q <= svec_pkg::SVEC_BMUTE;
               end else if (vol_ok && dn && al == `SVEC_TAP_MIN &&
                            ar == `SVEC_TAP_MIN) begin
                  st_q <= svec_pkg::SVEC_VMUTE;
               end
            end
            svec_pkg::SVEC_BMUTE: begin
               if (mute_press || up) begin
                  st_q <= svec_pkg::SVEC_RUN;
               end
            end
            svec_pkg::SVEC_VMUTE: begin
               if (mute_press || up) begin
                  st_q <= svec_pkg::SVEC_RUN;
               end
            end
            default: begin
               st_q <= svec_pkg::SVEC_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bal_q <= 1'h0;
      end else if (mode_press && !busy) begin
         bal_q <= !bal_q;
      end
   end

   // ==========================================================
   // click-free wiper update per channel
   // ==========================================================
   logic [5:0] tgt [2];
   logic [5:0] wip_q [2];
   logic [TW-1:0] tmr_q [2];
   // code n is 2n dB down, code 32 is mute
   always_comb begin
      if (down) begin
         tgt[0] = `SVEC_TAP_LOW;
         tgt[1] = `SVEC_TAP_LOW;
      end else if (st_q != svec_pkg::SVEC_RUN) begin
         tgt[0] = `SVEC_TAP_MUTE;
         tgt[1] = `SVEC_TAP_MUTE;
      end else begin
         tgt[0] = al;
         tgt[1] = ar;
      end
   end

   // timer starts with the shared step, so it also bounds
   // the lagging wiper after the first one has moved
   for (genvar c = 0; c < 2; c++) begin : g_wip
      always_ff @(posedge clock_i or negedge resetn_i) begin
         if (!resetn_i) begin
            wip_q[c] <= `SVEC_TAP_MUTE;
            tmr_q[c] <= '0;
         end else if (tgt[c] == wip_q[c]) begin
            tmr_q[c] <= '0;
         end else if (zero_cross_i[c] ||
                      tmr_q[c] == TW'(TMO_CYC - 1)) begin
            wip_q[c] <= tgt[c];
            tmr_q[c] <= '0;
         end else begin
            tmr_q[c] <= tmr_q[c] + TW'(1);
         end
      end
   end
   assign left_channel_tap_o = wip_q[0];
   assign right_channel_tap_o = wip_q[1];

   // ==========================================================
   // lamps
   // ==========================================================
   logic ctrl_q, mlamp_q;
   logic [4:0] lamp_q, bar, bpat;
   logic [5:0] lvl;
   logic signed [7:0] dif;
   assign lvl = (st_q != svec_pkg::SVEC_RUN) ? `SVEC_TAP_MUTE :
                (al < ar) ? al : ar;
   assign dif = 8'(signed'({2'h0, ar})) - 8'(signed'({2'h0, al}));

   always_comb begin
      if (lvl <= 6'h04) bar = 5'h1F;
      else if (lvl <= 6'h09) bar = 5'h0F;
      else if (lvl <= 6'h0E) bar = 5'h07;
      else if (lvl <= 6'h13) bar = 5'h03;
      else if (lvl <= 6'h1A) bar = 5'h01;
      else bar = 5'h00;
      // left quieter means balance shifted right
      if (dif == 8'sh00) bpat = 5'h04;
      else if (dif < 8'sh00 && -dif >= 8'(BAL_FAR)) bpat = 5'h10;
      else if (dif < 8'sh00) bpat = 5'h08;
      else if (dif >= 8'(BAL_FAR)) bpat = 5'h01;
      else bpat = 5'h02;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mlamp_q <= 1'h0;
         lamp_q <= 5'h00;
      end else begin
         mlamp_q <= bal_q && ctrl_q;
         lamp_q <= !ctrl_q ? 5'h00 : bal_q ? bpat : bar;
      end
   end
   assign mode_lamp_n_o = 1'h0;
   assign mode_lamp_oe_o = mlamp_q;
   assign level_lamp_n_o = 5'h00;
   assign level_lamp_oe_o = lamp_q;

   // ==========================================================
   // axi4-lite register slave
   // ==========================================================
   logic aw_q, w_q, bv_q, rv_q, wsel;
   logic [7:0] awa_q;
   logic [31:0] wd_q, rd_q, stat;
   logic [3:0] ws_q;
   logic [1:0] br_q, rr_q;
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign wsel = aw_q && w_q && !bv_q;
   assign stat = {13'h0000, down, st_q != svec_pkg::SVEC_RUN, bal_q,
                  2'h0, wip_q[1], 2'h0, wip_q[0]};

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_q <= 1'h0;
         w_q <= 1'h0;
         awa_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
         bv_q <= 1'h0;
         br_q <= `SVEC_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'h1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'h1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wsel) begin
            aw_q <= 1'h0;
            w_q <= 1'h0;
            bv_q <= 1'h1;
            br_q <= (awa_q == `SVEC_OFF_CTRL || awa_q == `SVEC_OFF_STAT)
                    ? `SVEC_RESP_OK : `SVEC_RESP_ERR;
         end else if (bv_q && s_axi_bready) begin
            bv_q <= 1'h0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= `SVEC_CTRL_RST;
      end else if (wsel && awa_q == `SVEC_OFF_CTRL && ws_q[0]) begin
         ctrl_q <= wd_q[0];
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rv_q <= 1'h0;
         rd_q <= 32'h00000000;
         rr_q <= `SVEC_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rv_q <= 1'h1;
         rr_q <= `SVEC_RESP_OK;
         if (s_axi_araddr == `SVEC_OFF_CTRL) begin
            rd_q <= {31'h00000000, ctrl_q};
         end else if (s_axi_araddr == `SVEC_OFF_STAT) begin
            rd_q <= stat;
         end else begin
            rd_q <= 32'h00000000;
            rr_q <= `SVEC_RESP_ERR;
         end
      end else if (rv_q && s_axi_rready) begin
         rv_q <= 1'h0;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   sequence s_mode_press;
      mode_press && !busy;
   endsequence
   sequence s_bottom_dn;
      vol_ok && dn && al == `SVEC_TAP_MIN && ar == `SVEC_TAP_MIN;
   endsequence
   property p_mode_toggle;
      s_mode_press |=> bal_q != $past(bal_q);
   endproperty
   a_mode_toggle: assert property (p_mode_toggle)
      else $error("mode did not toggle");
   property p_mode_lamp;
      s_mode_press ##1 (bal_q && ctrl_q) |=> mode_lamp_oe_o;
   endproperty
   a_mode_lamp: assert property (p_mode_lamp)
      else $error("mode lamp not on in balance");
   property p_zc_apply;
      tgt[0] != wip_q[0] && zero_cross_i[0] |=>
         wip_q[0] == $past(tgt[0]);
   endproperty
   a_zc_apply: assert property (p_zc_apply)
      else $error("left wiper ignored zero cross");
   property p_tmo;
      tgt[1] != wip_q[1] && tmr_q[1] == TW'(TMO_CYC - 1) |=>
         wip_q[1] == $past(tgt[1]);
   endproperty
   a_tmo: assert property (p_tmo)
      else $error("right wiper missed timeout");
   property p_vmute;
      (s_bottom_dn and !mute_press) |=> st_q == svec_pkg::SVEC_VMUTE;
   endproperty
   a_vmute: assert property (p_vmute)
      else $error("no mute below tap 31");
   property p_top;
      vol_ok && up && (ll_q == 7'h00 || lr_q == 7'h00) |=>
         $stable(ll_q) && $stable(lr_q);
   endproperty
   a_top: assert property (p_top)
      else $error("volume rose past top tap");
   property p_sep;
      vol_ok && up && ll_q != 7'h00 && lr_q != 7'h00 |=>
         ll_q == $past(ll_q) - 7'h01 && lr_q == $past(lr_q) - 7'h01;
   endproperty
   a_sep: assert property (p_sep)
      else $error("volume step broke separation");
   property p_hold;
      hold |=> $stable(ll_q) && $stable(lr_q) && $stable(bal_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("action on multiple buttons");
   property p_down;
      down |-> tgt[0] == `SVEC_TAP_LOW && tgt[1] == `SVEC_TAP_LOW;
   endproperty
   a_down: assert property (p_down)
      else $error("power down target wrong");
   property p_unmute;
      st_q == svec_pkg::SVEC_BMUTE && up |=> st_q == svec_pkg::SVEC_RUN;
   endproperty
   a_unmute: assert property (p_unmute)
      else $error("up step left mute on");
endmodule : svec_ctrl

// [logic/svec_cfg.svh]
// constants for the stereo volume encoder controller
// assumes a 40 MHz system clock
`ifndef SVEC_CFG_SVH
`define SVEC_CFG_SVH
`define SVEC_CLK_HZ 40000000
`define SVEC_DEB_MS 20
`define SVEC_TMO_MS 32
`define SVEC_DEB_CYC ((`SVEC_CLK_HZ / 1000) * `SVEC_DEB_MS)
`define SVEC_TMO_CYC ((`SVEC_CLK_HZ / 1000) * `SVEC_TMO_MS)
`define SVEC_TAP_POR 7'h06
`define SVEC_TAP_MIN 6'h1F
`define SVEC_TAP_MUTE 6'h20
`define SVEC_TAP_LOW 6'h20
`define SVEC_BAL_FAR 8
`define SVEC_OFF_CTRL 8'h00
`define SVEC_OFF_STAT 8'h04
`define SVEC_CTRL_RST 1'h1
`define SVEC_RESP_OK 2'h0
`define SVEC_RESP_ERR 2'h2
`endif

// [logic/svec_pkg.sv]
// types for the stereo volume encoder controller
// assumes svec_cfg.svh supplies the numeric constants
package svec_pkg;
   typedef enum logic [2:0] {
      SVEC_RUN = 3'h1,
      SVEC_BMUTE = 3'h2,
      SVEC_VMUTE = 3'h4
   } svec_st_t;
endpackage : svec_pkg

// [testbench/svec_knob_model.sv]
// rotary encoder and mute/mode pushbuttons facing the controller
// assumes tasks are called from the clock_i domain
`timescale 1ns/1ps
module svec_knob_model #(
   parameter int GAP = 14
) (
   // clock
   input wire logic clock_i,
   // contacts, low = closed, pulled high when open
   output logic phase_a_n_o,
   output logic phase_b_n_o,
   output logic mute_n_o,
   output logic mode_n_o
);
   // =========
   // contact state
   logic [1:0] pos = 2'h2;
   initial begin
      {phase_b_n_o, phase_a_n_o} = 2'h3;
      {mode_n_o, mute_n_o} = 2'h3;
   end
   // (B,A) pin levels, 00 01 11 10 is the rising count
   function automatic logic [1:0] gray(input logic [1:0] p);
      return {p[1], p[1] ^ p[0]};
   endfunction : gray
   // =========
   // actions
   task automatic hold();
      repeat (GAP) @(posedge clock_i);
   endtask : hold
   task automatic move(input logic [1:0] d);
      @(posedge clock_i);
      pos = pos + d;
      {phase_b_n_o, phase_a_n_o} <= gray(pos);
      hold();
   endtask : move
   task automatic step(input bit up);
      move(up ? 2'h1 : 2'h3);
   endtask : step
   // skips one state, not a legal transition
   task automatic jump();
      move(2'h2);
   endtask : jump
   // btn bit0 mute, bit1 mode
   task automatic press(input logic [1:0] btn);
      @(posedge clock_i);
      {mode_n_o, mute_n_o} <= ~btn;
      hold();
      @(posedge clock_i);
      {mode_n_o, mute_n_o} <= 2'h3;
      hold();
   endtask : press
endmodule : svec_knob_model

// [testbench/test_svec_ctrl.sv]
// self-checking bench for the volume controller
// assumes svec_knob_model plays the encoder and buttons
`timescale 1ns/1ps
`include "svec_cfg.svh"
module test_svec_ctrl;
   localparam int DEB = 4;
   localparam int TMO = 16;
   localparam int FAR = 8;
   localparam logic [1:0] OK = `SVEC_RESP_OK;
   localparam logic [1:0] ERR = `SVEC_RESP_ERR;
   logic clock_i, resetn_i, power_down_n_i;
   logic [1:0] zero_cross_i;
   logic pa_n, pb_n, mute_n, mode_n, mode_oe, mode_pin_n;
   logic [5:0] left_t, right_t;
   logic [4:0] lamp_oe, lamp_pins_n;
   logic [3:0] s_axi_wstrb;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   integer seed;
   int err_count, samples_checked, el, er, sv;
   bit bal, en, zc_rnd;
   logic [17:0] sq[$];
   logic [33:0] rq[$];
   logic [1:0] wq[$];
   // =========
   // clock, stimulus and instances
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
      zero_cross_i <= zc_rnd ? 2'($random(seed)) : 2'h0;
   svec_ctrl #(.DEB_CYC(DEB), .TMO_CYC(TMO), .BAL_FAR(FAR)) dut (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .encoder_phase_a_n_i(pa_n), .encoder_phase_b_n_i(pb_n),
      .mute_button_n_i(mute_n), .mode_button_n_i(mode_n),
      .power_down_n_i(power_down_n_i), .zero_cross_i(zero_cross_i),
      .left_channel_tap_o(left_t), .right_channel_tap_o(right_t),
      .mode_lamp_n_o(mode_pin_n), .mode_lamp_oe_o(mode_oe),
      .level_lamp_n_o(lamp_pins_n), .level_lamp_oe_o(lamp_oe),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   svec_knob_model #(.GAP(2 * (DEB + 2) + 2)) knob (
      .clock_i(clock_i), .phase_a_n_o(pa_n), .phase_b_n_o(pb_n),
      .mute_n_o(mute_n), .mode_n_o(mode_n));
   // =========
   // expectations and comparison
   function automatic logic [4:0] vol_lamps(input int t);
      if (t <= 4) return 5'h1F;
      if (t <= 9) return 5'h0F;
      if (t <= 14) return 5'h07;
      if (t <= 19) return 5'h03;
      if (t <= 26) return 5'h01;
      return 5'h00;
   endfunction : vol_lamps
   function automatic logic [4:0] bal_lamps(input int d);
      if (d == 0) return 5'h04;
      if (d >= FAR) return 5'h01;
      if (d > 0) return 5'h02;
      if (d <= -FAR) return 5'h10;
      return 5'h08;
   endfunction : bal_lamps
   task automatic chk_state(input logic [17:0] e, input logic [17:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD state exp %h got %h", e, g);
      end
   endtask : chk_state
   task automatic chk_word(input string n, input logic [31:0] e,
                           input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk_word
   task automatic expect_now();
      logic [4:0] lp;
      lp = bal ? bal_lamps(er - el) : vol_lamps(el < er ? el : er);
      sq.push_back({bal & en, en ? lp : 5'h00, 6'(er), 6'(el)});
   endtask : expect_now
   task automatic note();
      repeat (TMO + 4) @(posedge clock_i);
      expect_now();
   endtask : note
   always @(negedge clock_i)
      if (sq.size() != 0) begin
         chk_state(sq.pop_front(),
                   {mode_oe, lamp_oe, right_t, left_t});
         chk_word("lamp_n", 32'h0, 32'({mode_pin_n, lamp_pins_n}));
      end
   always @(posedge clock_i) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk_word("rdata", rq[0][31:0], s_axi_rdata);
         chk_word("rresp", 32'(rq.pop_front() >> 32), 32'(s_axi_rresp));
      end
      if (s_axi_bvalid && s_axi_bready)
         chk_word("bresp", 32'(wq.pop_front()), 32'(s_axi_bresp));
   end
   // =========
   // drivers
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r, input logic [3:0] s = 4'hF);
      bit pa, pw;
      wq.push_back(r);
      @(posedge clock_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
         @(posedge clock_i);
         if (pa && s_axi_awready) begin
            pa = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (pw && s_axi_wready) begin
            pw = 0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clock_i); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge clock_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock_i); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic turn(input bit up, input int n, input bit chk = 1);
      repeat (n) begin
         knob.step(up);
         if (!bal && up) begin
            if (el == 32) {el, er} = {32'h1F, 32'h1F};
            else if (el != 0 && er != 0) {el, er} = {el - 1, er - 1};
         end else if (!bal) begin
            if (el == 31 && er == 31) {el, er} = {32'h20, 32'h20};
            else {el, er} = {el + (el < 31), er + (er < 31)};
         end else if (up) begin
            if (er > el) er--;
            else if (el < 31) el++;
         end else begin
            if (el > er) el--;
            else if (er < 31) er++;
         end
         if (chk) note();
      end
   endtask : turn
   task automatic do_reset();
      @(posedge clock_i);
      resetn_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      {el, er, bal, en} = {32'h20, 32'h20, 1'b0, 1'b1};
   endtask : do_reset
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   // =========
   // scenarios
   initial begin
      repeat (30000) @(posedge clock_i);
      err_count++;
      final_report();
   end
   initial begin
      seed = 32'hdd2cd1fa;
      {resetn_i, power_down_n_i, zc_rnd} = 3'h2;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
      do_reset();
      expect_now();
      repeat (TMO - 4) @(posedge clock_i);
      // lamps already follow the -12 dB target, wipers still wait
      sq.push_back({1'b0, vol_lamps(6), 6'h20, 6'h20});
      {el, er} = {32'h06, 32'h06};
      note();
      axr(`SVEC_OFF_CTRL, 32'h0000_0001, OK);
      axr(`SVEC_OFF_STAT, 32'h0000_0606, OK);
      // low byte strobe off: enable must stay set
      axw(`SVEC_OFF_CTRL, 32'h0000_0000, OK, 4'hE);
      axr(`SVEC_OFF_CTRL, 32'h0000_0001, OK);
      axw(`SVEC_OFF_CTRL, 32'h0000_0000, OK);
      en = 0;
      note();
      axw(`SVEC_OFF_STAT, 32'hFFFF_FFFF, OK);
      axr(8'h08, 32'h0000_0000, ERR);
      axw(8'h0C, 32'h0000_0001, ERR);
      axw(`SVEC_OFF_CTRL, 32'h0000_0001, OK);
      en = 1;
      zc_rnd = 1;
      knob.jump();
      note();
      turn(1, 7);
      knob.press(2'h2);
      bal = 1;
      note();
      turn(1, 1);
      turn(0, 2);
      turn(1, 1);
      turn(1, FAR);
      knob.press(2'h2);
      bal = 0;
      note();
      turn(1, 1);
      turn(0, 31);
      turn(1, 9, 0);
      repeat (TMO + 4) @(posedge clock_i);
      chk_word("separation", 8, 32'(left_t - right_t));
      do_reset();
      {el, er} = {32'h06, 32'h06};
      note();
      turn(0, 26);
      axr(`SVEC_OFF_STAT, 32'h0002_2020, OK);
      turn(1, 1);
      turn(0, 1);
      knob.press(2'h1);
      {el, er} = {32'h1F, 32'h1F};
      note();
      turn(1, 3);
      sv = el;
      knob.press(2'h1);
      {el, er} = {32'h20, 32'h20};
      note();
      knob.press(2'h1);
      {el, er} = {sv, sv};
      note();
      knob.press(2'h1);
      knob.step(1);
      note();
      knob.press(2'h3);
      note();
      @(posedge clock_i);
      power_down_n_i <= 1'b0;
      {el, er} = {32'h20, 32'h20};
      note();
      power_down_n_i <= 1'b1;
      {el, er} = {sv, sv};
      note();
      final_report();
   end
endmodule : test_svec_ctrl
